// ---- dv/segment_map_and_bus_error_control_test.sv ----
// self-checking bench for smb_core with an external slave model
// driver notes expected cycle results in a queue, a monitor compares them
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
    $display("ERROR %s expected %h seen %h", nm, ex, got); n_mismatch++; end end
module segment_map_and_bus_error_control_test;
    typedef struct packed {
        logic flt; logic seen; logic mav; logic slow;
        logic [23:0] ba; logic [15:0] rd; logic [15:0] rm;
    } smb_exp_s;
    logic              clk = 1'b0, rst = 1'b1, par = 1'b0, ack_in, pav;
    smb_pkg::smb_req_s req = '0;
    logic [15:0]       wd = 16'h0000, rdata;
    logic [23:0]       baddr, ba_seen;
    logic [7:0]        dly = 8'h03;
    logic              bas, done_ack, flt, irq, oe, pclk, mavo;
    logic              saw = 1'b0, mv = 1'b0, mdone = 1'b0;
    smb_exp_s          q[$];
    smb_exp_s          e;
    logic [15:0]       ent [4];
    logic [23:0]       a_t [4] = '{24'h001123, 24'h002456, 24'h003789, 24'h200010};
    logic [7:0]        c_t [4] = '{8'h04, 8'h02, 8'h08, 8'h01};
    integer            n_mismatch = 0, n_checks = 0, seed = 32'hcfcb;
    integer            cycles = 0, cnt = 0, k, i;
    always #12.5 clk = ~clk;
    smb_core u_dut (.CORE_CLK(clk), .RST(rst), .CPU_REQ(req), .CPU_WDATA(wd),
        .BUS_ACK_IN(ack_in), .PARITY_ERR(par), .PERIPH_ADDR_VALID(pav), .BUS_ADDR(baddr),
        .BUS_AS(bas), .TRANSFER_DONE_ACK(done_ack), .BUS_FAULT_LINE(flt), .IRQ7(irq),
        .CPU_RDATA(rdata), .CPU_RDATA_OE(oe), .PERIPH_CLK(pclk), .MEM_ADDR_VALID_OUT(mavo));
    smb_slave_model u_slave (.CORE_CLK(clk), .RST(rst), .BUS_AS(bas), .BUS_ADDR(baddr),
        .DLY(dly), .BUS_ACK_IN(ack_in), .PERIPH_ADDR_VALID(pav));
    function automatic smb_exp_s rg(input logic [15:0] r, input logic [15:0] m);
        rg = '{default: '0, rd: r, rm: m};
    endfunction : rg
    function automatic smb_exp_s blk(input logic f);
        blk = '{default: '0, flt: f, slow: 1'b1};
    endfunction : blk
    function automatic smb_exp_s ext(input logic [23:0] b, input logic f, m, sl);
        ext = '{default: '0, flt: f, seen: 1'b1, mav: m, slow: sl, ba: b};
    endfunction : ext
    task summarize;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize
    task automatic tend(input string s);
        $display("test %s done", s);
    endtask : tend
    task automatic cyc(input logic [2:0] fc, input logic rw, input logic [23:0] a,
                       input logic lm, input logic [15:0] d, input smb_exp_s x);
        q.push_back(x);
        @(posedge clk);
        req <= '{addr: a, as: 1'b1, rw: rw, uds: 1'b1, lds: 1'b1, fc: fc, local_master: lm};
        wd  <= d;
        for (int j = 0; j < 400; j++) begin
            @(posedge clk);
            #2;
            if (mdone) break;
        end
        if (!mdone) begin
            n_mismatch++;
            void'(q.pop_back());
        end
        @(posedge clk);
        req.as <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : cyc
    // monitor: one result per strobe, taken at the first ack or fault
    always @(posedge clk) begin
        #1;
        if (!req.as) begin
            saw = 1'b0; mv = 1'b0; cnt = 0; mdone = 1'b0;
        end else begin
            cnt++;
            if (bas) begin saw = 1'b1; ba_seen = baddr; end
            if (mavo) mv = 1'b1;
            if (!mdone && (done_ack || flt)) begin
                mdone = 1'b1;
                e = q.pop_front();
                `CHK("fault", e.flt, flt)
                `CHK("strobe", e.seen, saw)
                if (e.seen) `CHK("addr", e.ba, ba_seen)
                `CHK("rdata", e.rd, rdata & e.rm)
                `CHK("mav", e.mav, mv)
                `CHK("oe", (e.rm != 16'h0000), oe)
                if (e.slow) `CHK("wait", 1'b1, (cnt >= 152 && cnt <= 164))
            end
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            summarize();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        cyc(smb_pkg::FC_SDATA, 1'b1, smb_pkg::ERR_ADDR, 1'b1, 16'h0000, rg(16'h0080, 16'h00FF));
        tend("reset");
        for (i = 0; i < 4; i++) begin
            ent[i] = {1'b0, i != 2, i != 1, i != 3, 12'($random(seed))};
            cyc(smb_pkg::FC_SDATA, 1'b0, smb_pkg::MAP_BASE + 24'(2 * i), 1'b1, ent[i],
                rg(16'h0000, 16'h0000));
            cyc(smb_pkg::FC_SDATA, 1'b1, smb_pkg::MAP_BASE + 24'(2 * i), 1'b1, 16'h0000,
                rg(ent[i], 16'hFFFF));
        end
        cyc(smb_pkg::FC_SDATA, 1'b1, smb_pkg::MAP_BASE, 1'b0, 16'h0000, blk(1'b1));
        cyc(smb_pkg::FC_UDATA, 1'b1, 24'h000ABC, 1'b1, 16'h0000,
            ext({ent[0][11:0], 12'hABC}, 1'b0, 1'b0, 1'b0));
        tend("translate");
        for (i = 0; i < 4; i++) begin
            cyc(i == 0 ? smb_pkg::FC_UPROG : smb_pkg::FC_UDATA, i != 1, a_t[i], 1'b1,
                16'h0000, blk(1'b0));
            `CHK("irq set", 1'b1, irq)
            cyc(smb_pkg::FC_SDATA, 1'b1, smb_pkg::ERR_ADDR, 1'b1, 16'h0000,
                rg({8'h00, c_t[i]}, 16'h00FF));
            `CHK("irq clear", 1'b0, irq)
            cyc(smb_pkg::FC_SDATA, 1'b1, smb_pkg::ERR_ADDR, 1'b1, 16'h0000,
                rg({8'h00, 8'h80 | c_t[i]}, 16'h00FF));
        end
        cyc(smb_pkg::FC_UDATA, 1'b1, a_t[0], 1'b1, 16'h0000, blk(1'b0));
        cyc(smb_pkg::FC_UDATA, 1'b0, a_t[1], 1'b1, 16'h0000, blk(1'b0));
        cyc(smb_pkg::FC_SDATA, 1'b1, smb_pkg::ERR_ADDR, 1'b1, 16'h0000,
            rg(16'h0004, 16'h00FF));
        @(posedge clk) par <= 1'b1;
        @(posedge clk) par <= 1'b0;
        cyc(smb_pkg::FC_SDATA, 1'b1, 24'h400000, 1'b1, 16'h0000, blk(1'b0));
        cyc(smb_pkg::FC_SDATA, 1'b1, smb_pkg::ERR_ADDR, 1'b1, 16'h0000,
            rg(16'h0010, 16'h00FF));
        tend("errors");
        cyc(smb_pkg::FC_SDATA, 1'b0, smb_pkg::FLAG_ADDR, 1'b1, {8'h00, smb_pkg::FLAG_SET},
            rg(16'h0000, 16'h0000));
        cyc(smb_pkg::FC_SDATA, 1'b1, smb_pkg::FLAG_ADDR, 1'b1, 16'h0000,
            rg(16'h0000, 16'h00FF));
        cyc(smb_pkg::FC_SDATA, 1'b1, 24'h000ABC, 1'b1, 16'h0000,
            ext({ent[0][11:0], 12'hABC}, 1'b0, 1'b0, 1'b0));
        cyc(smb_pkg::FC_IACK, 1'b1, 24'hFFFFFF, 1'b1, 16'h0000,
            ext(24'hFFFFFF, 1'b0, 1'b0, 1'b0));
        cyc(smb_pkg::FC_SDATA, 1'b1, 24'h000ABC, 1'b1, 16'h0000,
            ext(24'h000ABC, 1'b0, 1'b0, 1'b0));
        tend("flag");
        dly <= 8'h00;
        cyc(smb_pkg::FC_SDATA, 1'b1, 24'h400000, 1'b1, 16'h0000,
            ext(24'h400000, 1'b1, 1'b0, 1'b1));
        dly <= 8'd100;
        cyc(smb_pkg::FC_SDATA, 1'b1, 24'h400000, 1'b1, 16'h0000,
            ext(24'h400000, 1'b0, 1'b0, 1'b0));
        dly <= 8'd60;
        cyc(smb_pkg::FC_SDATA, 1'b1, 24'hF00010, 1'b1, 16'h0000,
            ext(24'hF00010, 1'b0, 1'b1, 1'b0));
        dly <= 8'h03;
        tend("timer");
        @(posedge pclk);
        #1;
        for (k = 1; k < 100; k++) begin @(posedge clk); #1; if (!pclk) break; end
        `CHK("clk high", smb_pkg::E_PERIOD_CYC - smb_pkg::E_LOW_CYC, k)
        for (k = 1; k < 100; k++) begin @(posedge clk); #1; if (pclk) break; end
        `CHK("clk low", smb_pkg::E_LOW_CYC, k)
        tend("pclk");
        summarize();
    end
endmodule : segment_map_and_bus_error_control_test

// ---- dv/smb_slave_model.sv ----
// external slave on the translated bus side of the block
// answers each strobed cycle after DLY cycles, DLY of zero never answers
`timescale 1ns/1ps
module smb_slave_model (
    input  wire logic        CORE_CLK,         // core clock
    input  wire logic        RST,              // synchronous reset, high
    input  wire logic        BUS_AS,           // gated strobe from the block
    input  wire logic [23:0] BUS_ADDR,         // translated address
    input  wire logic [7:0]  DLY,              // cycles to acknowledge, 0 never
    output logic             BUS_ACK_IN,       // acknowledge back to the block
    output logic             PERIPH_ADDR_VALID // slow peripheral claims the cycle
);
    logic [7:0] wait_reg = 8'h00;
    logic       ack_reg  = 1'b0;
    always @(posedge CORE_CLK) begin
        if (RST || !BUS_AS) begin
            wait_reg <= 8'h00;
            ack_reg  <= 1'b0;
        end else begin
            wait_reg <= wait_reg + 8'h01;
            ack_reg  <= (DLY != 8'h00) && ((wait_reg + 8'h01) >= DLY);
        end
    end
    assign BUS_ACK_IN = ack_reg;
    // slow peripherals sit in the F0 page; released line reads low
    assign PERIPH_ADDR_VALID = BUS_AS && (BUS_ADDR[23:16] == 8'hF0);
endmodule : smb_slave_model

// ---- logic/smb_core.sv ----
// segment translation, access checking, fault capture and bus timeout
// assumes a synchronous request bus and acknowledge/parity inputs on CORE_CLK
//
// Overview of operation
// - timeout counter ticks at 4 MHz, cleared while no address strobe
// - after 16 counter ticks with strobe held, bus fault line asserts
// - acknowledge before 16 ticks stops counter; strobe release clears it
// - violation or parity error keeps strobe off the external bus
// - timeout of blocked cycle latches errors and acknowledges, no bus fault
// - peripheral clock period ten 125 ns clocks, six low, four high
// - peripheral address valid answered by memory address valid output
// - cycle type code decoded into user/supervisor data/program and iack
// - mapped addresses ignore bits 21-23, bits 12-20 pick one of 512 entries
// - entry's 12-bit physical segment replaces upper 12 address bits
// - entry: bit14 writable, bit13 valid, bit12 resident, bits 11-0 segment
// - map entries readable and writable from byte address EFF800
// - only local processor may reach map entries; other registers open to all
// - mapped access outside 000000-1FFFFF is access violation; unmapped errs only on parity
// - protected write, invalid entry, nonresident entry each flagged
// - any error latches its type and raises level seven interrupt
// - captured errors frozen and interrupt held until the register is read
// - flags in bits 0-4, bits 5-6 zero, bit 7 zero while error active
// - capture only at acknowledge with error present; read clears interrupt only
// - supervisor below 2 MB mapped when flag is one, else passed through
// - write 80 to EFFC01 sets flag, 00 clears; unreadable; reset and iack clear
// - fault register read-only at EFFD01; reading clears pending interrupt
`timescale 1ns/1ps
module smb_core (
    input  wire logic              CORE_CLK,          // 40 MHz core clock
    input  wire logic              RST,               // synchronous reset, high
    input  wire smb_pkg::smb_req_s CPU_REQ,           // request from bus master
    input  wire logic [15:0]       CPU_WDATA,         // write data
    input  wire logic              BUS_ACK_IN,        // transfer_done_ack from slave
    input  wire logic              PARITY_ERR,        // parity error pulse
    input  wire logic              PERIPH_ADDR_VALID, // periph_addr_valid, high
    output logic [23:0]            BUS_ADDR,          // translated address
    output logic                   BUS_AS,            // gated address strobe
    output logic                   TRANSFER_DONE_ACK, // transfer_done_ack to master
    output logic                   BUS_FAULT_LINE,    // bus_fault_line, high
    output logic                   IRQ7,              // level seven request
    output logic [15:0]            CPU_RDATA,         // read data
    output logic                   CPU_RDATA_OE,      // read data driven
    output logic                   PERIPH_CLK,        // slow peripheral clock
    output logic                   MEM_ADDR_VALID_OUT // mem_addr_valid_out, high
);

    function automatic smb_pkg::smb_cyc_e decode_fc(input logic [2:0] fc);
        case (fc)
            smb_pkg::FC_UDATA: decode_fc = smb_pkg::CYC_UDATA;
            smb_pkg::FC_UPROG: decode_fc = smb_pkg::CYC_UPROG;
            smb_pkg::FC_SDATA: decode_fc = smb_pkg::CYC_SDATA;
            smb_pkg::FC_SPROG: decode_fc = smb_pkg::CYC_SPROG;
            smb_pkg::FC_IACK:  decode_fc = smb_pkg::CYC_IACK;
            default:           decode_fc = smb_pkg::CYC_RSVD;
        endcase
    endfunction : decode_fc

    logic [15:0] map_mem [smb_pkg::MAP_DEPTH];

    smb_pkg::smb_tmr_e          tst_reg, tst_next;
    logic [4:0]                 cnt_reg, cnt_next;
    logic [3:0]                 tdiv_reg, tdiv_next;
    logic                       fault_reg, fault_next;
    logic                       tack_reg, tack_next;
    logic                       cap;
    logic                       blk_reg, blk_next;
    logic [smb_pkg::ERR_N-1:0]  ecyc_reg, ecyc_next;
    logic [smb_pkg::ERR_N-1:0]  err_reg, err_next;
    logic                       irq_reg, irq_next;
    logic                       par_reg, par_next;
    logic                       flag_reg, flag_next;
    logic                       lack_reg, lack_next;
    logic [15:0]                rdat_reg, rdat_next;
    logic [23:0]                badr_reg, badr_next;
    logic                       bas_reg, bas_next;
    logic [5:0]                 ecnt_reg, ecnt_next;
    logic                       pclk_reg, pclk_next;
    logic                       mav_reg, mav_next;

    smb_pkg::smb_cyc_e          cyc;
    logic                       iack, user, in_usp, mapped, tick, ack_seen;
    logic                       map_sel, flag_sel, err_sel, loc_sel, loc_ok, loc_stb;
    logic                       err_rd, cap_ok, map_we_hi, map_we_lo;
    logic [8:0]                 seg_idx, map_idx;
    logic [15:0]                entry;
    logic [smb_pkg::ERR_N-1:0]  err_now;
    logic [7:0]                 err_byte;

    // decode and translation
    always_comb begin
        cyc     = decode_fc(CPU_REQ.fc);
        iack    = (cyc == smb_pkg::CYC_IACK);
        user    = ~CPU_REQ.fc[smb_pkg::FC_SUPER];
        in_usp  = (CPU_REQ.addr[23:smb_pkg::USR_LSB] == 3'h0);
        seg_idx = CPU_REQ.addr[smb_pkg::SEG_MSB:smb_pkg::SEG_LSB];
        map_idx = CPU_REQ.addr[smb_pkg::MAP_SEL_LSB-1:smb_pkg::WORD_LSB];
        entry   = map_mem[seg_idx];
        mapped  = CPU_REQ.as & CPU_REQ.local_master & ~iack
                & (user | (flag_reg & in_usp));
        err_now = '0;
        err_now[smb_pkg::ERR_AV]  = mapped & ~in_usp;
        err_now[smb_pkg::ERR_WV]  = mapped & ~CPU_REQ.rw & ~entry[smb_pkg::ENT_WR];
        err_now[smb_pkg::ERR_INV] = mapped & ~entry[smb_pkg::ENT_VALID];
        err_now[smb_pkg::ERR_NR]  = mapped & ~entry[smb_pkg::ENT_RES];
        err_now[smb_pkg::ERR_PAR] = CPU_REQ.as & par_reg;
        map_sel  = (CPU_REQ.addr[23:smb_pkg::MAP_SEL_LSB]
                   == smb_pkg::MAP_BASE[23:smb_pkg::MAP_SEL_LSB]);
        flag_sel = (CPU_REQ.addr[23:smb_pkg::WORD_LSB]
                   == smb_pkg::FLAG_ADDR[23:smb_pkg::WORD_LSB]);
        err_sel  = (CPU_REQ.addr[23:smb_pkg::WORD_LSB]
                   == smb_pkg::ERR_ADDR[23:smb_pkg::WORD_LSB]);
        loc_sel  = ~mapped & (map_sel | flag_sel | err_sel);
        loc_ok   = ~map_sel | CPU_REQ.local_master;
        loc_stb  = CPU_REQ.as & loc_sel & loc_ok & ~lack_reg;
        err_rd   = loc_stb & err_sel & CPU_REQ.rw & CPU_REQ.lds;
        map_we_hi = loc_stb & map_sel & ~CPU_REQ.rw & CPU_REQ.uds;
        map_we_lo = loc_stb & map_sel & ~CPU_REQ.rw & CPU_REQ.lds;
        err_byte = {~irq_reg, 2'b00, err_reg};
    end

    always_ff @(posedge CORE_CLK) begin
        if (map_we_hi) begin
            map_mem[map_idx][15:8] <= CPU_WDATA[15:8];
        end
        if (map_we_lo) begin
            map_mem[map_idx][7:0] <= CPU_WDATA[7:0];
        end
    end

    // local registers, strobe gating and translated address
    always_comb begin
        flag_next = flag_reg;
        if (CPU_REQ.as & iack & (tst_reg == smb_pkg::TM_IDLE)) begin
            flag_next = 1'b0;
        end else if (loc_stb & flag_sel & ~CPU_REQ.rw & CPU_REQ.lds) begin
            if (CPU_WDATA[7:0] == smb_pkg::FLAG_SET) begin
                flag_next = 1'b1;
            end else if (CPU_WDATA[7:0] == smb_pkg::FLAG_CLR) begin
                flag_next = 1'b0;
            end
        end
        lack_next = CPU_REQ.as & loc_sel & loc_ok;
        rdat_next = rdat_reg;
        if (loc_stb & CPU_REQ.rw) begin
            if (map_sel) begin
                rdat_next = map_mem[map_idx];
            end else if (err_sel) begin
                rdat_next = {8'h00, err_byte};
            end else begin
                rdat_next = 16'h0000;
            end
        end
        bas_next  = CPU_REQ.as & ~loc_sel & ~(|err_now) & ~blk_reg;
        badr_next = mapped ? {entry[smb_pkg::PSEG_W-1:0],
                              CPU_REQ.addr[smb_pkg::SEG_LSB-1:0]}
                           : CPU_REQ.addr;
        blk_next  = CPU_REQ.as & (blk_reg | (|err_now));
        ecyc_next = CPU_REQ.as ? (ecyc_reg | err_now) : '0;
    end

    // bus timeout counter
    always_comb begin
        tick      = (tdiv_reg == 4'(smb_pkg::TMR_DIV - 1));
        tdiv_next = tick ? 4'h0 : tdiv_reg + 4'h1;
        ack_seen  = BUS_ACK_IN | lack_reg | PERIPH_ADDR_VALID;
        tst_next   = tst_reg;
        cnt_next   = cnt_reg;
        fault_next = fault_reg;
        tack_next  = tack_reg;
        cap        = 1'b0;
        if (!CPU_REQ.as) begin
            tst_next   = smb_pkg::TM_IDLE;
            cnt_next   = 5'h00;
            fault_next = 1'b0;
            tack_next  = 1'b0;
        end else begin
            case (tst_reg)
                smb_pkg::TM_IDLE: begin
                    tst_next = smb_pkg::TM_COUNT;
                end
                smb_pkg::TM_COUNT: begin
                    if (ack_seen) begin
                        tst_next = smb_pkg::TM_STOP;
                    end else if (tick) begin
                        cnt_next = cnt_reg + 5'h01;
                        if (cnt_reg == 5'(smb_pkg::TIMEOUT_CNT - 1)) begin
                            tst_next = smb_pkg::TM_DONE;
                            if (blk_reg) begin
                                tack_next = 1'b1;
                                cap       = 1'b1;
                            end else begin
                                fault_next = 1'b1;
                            end
                        end
                    end
                end
                smb_pkg::TM_STOP: begin
                    tst_next = smb_pkg::TM_STOP;
                end
                smb_pkg::TM_DONE: begin
                    tst_next = smb_pkg::TM_DONE;
                end
                default: begin
                    tst_next = smb_pkg::TM_IDLE;
                end
            endcase
        end
    end

    // fault capture and interrupt; a new capture wins over a same-cycle read
    always_comb begin
        cap_ok   = cap & (|ecyc_reg) & (~irq_reg | err_rd);
        err_next = cap_ok ? ecyc_reg : err_reg;
        irq_next = cap_ok | (irq_reg & ~err_rd);
        par_next = PARITY_ERR | (par_reg & ~cap_ok);
    end

    // peripheral clock and memory address valid
    always_comb begin
        ecnt_next = (ecnt_reg == 6'(smb_pkg::E_PERIOD_CYC - 1)) ? 6'h00 : ecnt_reg + 6'h01;
        pclk_next = (ecnt_next >= 6'(smb_pkg::E_LOW_CYC));
        mav_next  = CPU_REQ.as & PERIPH_ADDR_VALID
                  & (mav_reg | (ecnt_reg == 6'(smb_pkg::E_PERIOD_CYC - 1)));
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            tst_reg  <= smb_pkg::TM_IDLE;
            cnt_reg  <= 5'h00;
            tdiv_reg <= 4'h0;
            fault_reg <= 1'b0;
            tack_reg <= 1'b0;
            blk_reg  <= 1'b0;
            ecyc_reg <= '0;
            err_reg  <= '0;
            irq_reg  <= 1'b0;
            par_reg  <= 1'b0;
            flag_reg <= 1'b0;
            lack_reg <= 1'b0;
            rdat_reg <= 16'h0000;
            badr_reg <= 24'h000000;
            bas_reg  <= 1'b0;
            ecnt_reg <= 6'h00;
            pclk_reg <= 1'b0;
            mav_reg  <= 1'b0;
        end else begin
            tst_reg  <= tst_next;
            cnt_reg  <= cnt_next;
            tdiv_reg <= tdiv_next;
            fault_reg <= fault_next;
            tack_reg <= tack_next;
            blk_reg  <= blk_next;
            ecyc_reg <= ecyc_next;
            err_reg  <= err_next;
            irq_reg  <= irq_next;
            par_reg  <= par_next;
            flag_reg <= flag_next;
            lack_reg <= lack_next;
            rdat_reg <= rdat_next;
            badr_reg <= badr_next;
            bas_reg  <= bas_next;
            ecnt_reg <= ecnt_next;
            pclk_reg <= pclk_next;
            mav_reg  <= mav_next;
        end
    end

    assign BUS_ADDR           = badr_reg;
    assign BUS_AS             = bas_reg;
    assign TRANSFER_DONE_ACK  = BUS_ACK_IN | lack_reg | tack_reg;
    assign BUS_FAULT_LINE     = fault_reg;
    assign IRQ7               = irq_reg;
    assign CPU_RDATA          = rdat_reg;
    assign CPU_RDATA_OE       = lack_reg & CPU_REQ.rw;
    assign PERIPH_CLK         = pclk_reg;
    assign MEM_ADDR_VALID_OUT = mav_reg;

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    timer_clear_a: assert property (!CPU_REQ.as |=> cnt_reg == 5'h00)
        else $error("timeout counter not cleared without strobe");
    fault_at_16_a: assert property ($rose(BUS_FAULT_LINE)
        |-> cnt_reg == 5'(smb_pkg::TIMEOUT_CNT) && !tack_reg)
        else $error("bus fault not at sixteenth count");
    timer_stop_a: assert property (tst_reg == smb_pkg::TM_STOP && CPU_REQ.as
        |=> $stable(cnt_reg))
        else $error("counter moved after acknowledge");
    strobe_block_a: assert property (CPU_REQ.as && |err_now |=> !BUS_AS)
        else $error("strobe reached bus despite error");
    blocked_ack_a: assert property ($rose(tack_reg) |-> !BUS_FAULT_LINE && TRANSFER_DONE_ACK)
        else $error("blocked timeout raised fault or no ack");
    pclk_low_a: assert property ($rose(PERIPH_CLK) |-> ecnt_reg == 6'(smb_pkg::E_LOW_CYC))
        else $error("peripheral clock low phase wrong");
    pclk_high_a: assert property ($fell(PERIPH_CLK) |-> ecnt_reg == 6'h00)
        else $error("peripheral clock period wrong");
    mav_cause_a: assert property (MEM_ADDR_VALID_OUT
        |-> $past(CPU_REQ.as && PERIPH_ADDR_VALID))
        else $error("memory address valid without peripheral");
    iack_flag_a: assert property (CPU_REQ.as && iack && tst_reg == smb_pkg::TM_IDLE
        |=> !flag_reg)
        else $error("mapping flag survived interrupt acknowledge");
    err_freeze_a: assert property (IRQ7 && !cap_ok |=> $stable(err_reg))
        else $error("fault register changed while frozen");
    irq_clear_a: assert property (err_rd && !cap_ok |=> !IRQ7 && $stable(err_reg))
        else $error("read did not clear interrupt only");
    phys_addr_a: assert property (mapped |=> BUS_ADDR[11:0] == $past(CPU_REQ.addr[11:0]))
        else $error("segment offset not preserved");
    usp_viol_a: assert property (mapped && !in_usp |=> ecyc_reg[smb_pkg::ERR_AV])
        else $error("access violation not flagged");

    timeout_fault_c: cover property ($rose(BUS_FAULT_LINE));
    blocked_ack_c:   cover property ($rose(tack_reg) && $rose(IRQ7));
    err_read_c:      cover property (IRQ7 && err_rd);
    mav_c:           cover property ($rose(MEM_ADDR_VALID_OUT));

endmodule : smb_core

// ---- shared/smb_pkg.sv ----
// constants, types and register map of the segment map and bus error block
// assumes one 40 MHz core clock; all bus inputs are synchronous to it
package smb_pkg;

    // timing
    localparam int CORE_PERIOD_NS = 25;
    localparam int TMR_CLK_NS     = 250;
    localparam int TMR_DIV        = TMR_CLK_NS / CORE_PERIOD_NS;
    localparam int TIMEOUT_NS     = 4000;
    localparam int TIMEOUT_CNT    = TIMEOUT_NS / TMR_CLK_NS;
    localparam int SYS_CLK_NS     = 125;
    localparam int E_LOW_CLKS     = 6;
    localparam int E_HIGH_CLKS    = 4;
    localparam int E_LOW_CYC      = (E_LOW_CLKS * SYS_CLK_NS) / CORE_PERIOD_NS;
    localparam int E_PERIOD_CYC   = ((E_LOW_CLKS + E_HIGH_CLKS) * SYS_CLK_NS) / CORE_PERIOD_NS;

    // register map (byte addresses)
    localparam logic [23:0] MAP_BASE  = 24'hEFF800;
    localparam logic [23:0] FLAG_ADDR = 24'hEFFC01;
    localparam logic [23:0] ERR_ADDR  = 24'hEFFD01;
    localparam int          MAP_SEL_LSB = 10;
    localparam int          WORD_LSB    = 1;

    // address fields
    localparam int SEG_LSB = 12;
    localparam int SEG_MSB = 20;
    localparam int USR_LSB = 21;
    localparam int MAP_DEPTH = 512;

    // map entry fields
    localparam int ENT_WR    = 14;
    localparam int ENT_VALID = 13;
    localparam int ENT_RES   = 12;
    localparam int PSEG_W    = 12;

    // fault_capture bits
    localparam int ERR_AV   = 0;
    localparam int ERR_WV   = 1;
    localparam int ERR_INV  = 2;
    localparam int ERR_NR   = 3;
    localparam int ERR_PAR  = 4;
    localparam int ERR_N    = 5;
    localparam logic [7:0] FLAG_SET = 8'h80;
    localparam logic [7:0] FLAG_CLR = 8'h00;

    // cycle_type_code values
    localparam logic [2:0] FC_UDATA = 3'h1;
    localparam logic [2:0] FC_UPROG = 3'h2;
    localparam logic [2:0] FC_SDATA = 3'h5;
    localparam logic [2:0] FC_SPROG = 3'h6;
    localparam logic [2:0] FC_IACK  = 3'h7;
    localparam int         FC_SUPER = 2;

    typedef enum logic [5:0] {
        CYC_RSVD  = 6'h01,
        CYC_UDATA = 6'h02,
        CYC_UPROG = 6'h04,
        CYC_SDATA = 6'h08,
        CYC_SPROG = 6'h10,
        CYC_IACK  = 6'h20
    } smb_cyc_e;

    typedef enum logic [3:0] {
        TM_IDLE  = 4'h1,
        TM_COUNT = 4'h2,
        TM_STOP  = 4'h4,
        TM_DONE  = 4'h8
    } smb_tmr_e;

    typedef struct packed {
        logic [23:0] addr;         // byte address from processor or master
        logic        as;           // address strobe, active high
        logic        rw;           // 1 read, 0 write
        logic        uds;          // upper byte strobe
        logic        lds;          // lower byte strobe
        logic [2:0]  fc;           // cycle_type_code
        logic        local_master; // local processor owns the bus
    } smb_req_s;

endpackage : smb_pkg
